/* common/pmrp_pkg.sv */
package pmrp_pkg;

	// Register command codes.
	localparam logic [7:0] CMD_GAIN      = 8'h38;
	localparam logic [7:0] CMD_BUS_RES   = 8'h8b;
	localparam logic [7:0] CMD_CUR_RES   = 8'h8c;
	localparam logic [7:0] CMD_TEMP_RES  = 8'h8d;
	localparam logic [7:0] CMD_ICFG      = 8'hd4;
	localparam logic [7:0] CMD_VCFG      = 8'hd5;
	localparam logic [7:0] CMD_SHUNT_RES = 8'hd6;
	localparam logic [7:0] CMD_PEAK_CFG  = 8'hd7;
	localparam logic [7:0] CMD_PEAK_MIN  = 8'hd8;
	localparam logic [7:0] CMD_PEAK_MAX  = 8'hd9;
	localparam logic [7:0] CMD_EXCITE    = 8'he2;

	// Field layout of both channel configuration words.
	localparam int PRI_CT_LSB  = 0;
	localparam int PRI_AVG_LSB = 3;
	localparam int AUX_CT_LSB  = 7;
	localparam int AUX_AVG_LSB = 10;
	localparam int CFG_WIDTH   = 14;
	localparam int GAIN_WIDTH  = 15;
	localparam int PEAK_EN_BIT = 0;
	localparam int EXC_EN_BIT  = 0;

	// Reset values.
	localparam logic [13:0] CFG_RESET  = 14'h0387;
	localparam logic [14:0] GAIN_RESET = 15'h0000;

	// Operating mode codes.
	localparam logic [2:0] MODE_SHUNT     = 3'h0;
	localparam logic [2:0] MODE_BUS       = 3'h1;
	localparam logic [2:0] MODE_SHUNT_BUS = 3'h2;
	localparam logic [2:0] MODE_TEMP      = 3'h6;
	localparam logic [2:0] MODE_ALL       = 3'h7;

	// Measurement channels in conversion order.
	localparam logic [1:0] CH_SHUNT = 2'h0;
	localparam logic [1:0] CH_BUS   = 2'h1;
	localparam logic [1:0] CH_TEMP  = 2'h2;
	localparam logic [1:0] CH_NONE  = 2'h3;

	// Timing.
	localparam int CLK_PERIOD_PS   = 25000;
	localparam int CONV_BASE_PS    = 64000000;
	localparam int CONV_BASE_CYC   = CONV_BASE_PS / CLK_PERIOD_PS;
	localparam int EXCITE_PS       = 1000000;
	localparam int EXCITE_CYC      = EXCITE_PS / CLK_PERIOD_PS;
	localparam int EXCITE_HALF_CYC = EXCITE_CYC / 2;

	// Arithmetic.
	localparam int MATH_SHIFT    = 11;
	localparam int AVG_MAX_SHIFT = 12;
	localparam int ACC_WIDTH     = 29;

	// Register access request from the serial front end.
	typedef struct packed {
		logic [7:0]  cmd;
		logic        wr;
		logic        rd;
		logic [15:0] wdata;
	} pmrp_req_s;

	// Mode register fields owned by the surrounding core.
	typedef struct packed {
		logic       powerdown;
		logic       continuous;
		logic [2:0] op_mode;
	} pmrp_mode_s;

endpackage : pmrp_pkg

/* tb/pmrp_adc_model.sv */
`timescale 1ns/10ps

// Converter model: answers each channel with the level that the bench sets.
module pmrp_adc_model
	import pmrp_pkg::*;
(
	// Channel select and levels.
	input  wire logic [1:0]  chan_i,
	input  wire logic [15:0] shunt_i,
	input  wire logic [15:0] bus_i,
	input  wire logic [15:0] temp_i,
	// Sample to the block.
	output logic [15:0]      data_o
);
	// An idle channel reads the inverted shunt level, never a stale value.
	assign data_o = (chan_i == CH_SHUNT) ? shunt_i : (chan_i == CH_BUS) ? bus_i :
		(chan_i == CH_TEMP) ? temp_i : ~shunt_i;
endmodule : pmrp_adc_model

/* tb/pmrp_monitor_chk.sv */
`timescale 1ns/10ps

// Checks the monitor at its ports.
module pmrp_monitor_chk
	import pmrp_pkg::*;
#(
	parameter int CONV_CYC = CONV_BASE_CYC
) (
	// Clock and reset.
	input wire logic        clk_i,
	input wire logic        resetn_i,
	// Register port and mode.
	input wire pmrp_req_s   req_i,
	input wire logic [15:0] rdata_o,
	input wire pmrp_mode_s  mode_i,
	// Converter and aux front end.
	input wire logic [1:0]  adc_chan_o,
	input wire logic        adc_sample_o,
	input wire logic        diode_mode_o,
	input wire logic        excite_o,
	input wire logic        excite_high_o,
	input wire logic        busy_o
);
	// Counts the cycles that the excitation window has stood so far.
	logic [7:0] exc_cnt;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			exc_cnt <= 8'h00;
		else
			exc_cnt <= excite_o ? exc_cnt + 8'h01 : 8'h00;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	// Unused bits read back as zero.
	property p_gain_rd; req_i.rd && req_i.cmd == CMD_GAIN |=> !rdata_o[15]; endproperty
	a_gain_rd: assert property (p_gain_rd)
		else $error("gain bit 15 not zero");
	property p_vcfg_rd; req_i.rd && req_i.cmd == CMD_VCFG |=> rdata_o[15:14] == 2'h0; endproperty
	a_vcfg_rd: assert property (p_vcfg_rd)
		else $error("voltage config top bits not zero");
	property p_peak_rd; req_i.rd && req_i.cmd == CMD_PEAK_CFG |=> rdata_o[15:1] == 15'h0000; endproperty
	a_peak_rd: assert property (p_peak_rd)
		else $error("peak config upper bits not zero");
	// The excitation window is 40 cycles with the high current in the last 20.
	property p_exc_len; $fell(excite_o) |-> exc_cnt == 8'h28; endproperty
	a_exc_len: assert property (p_exc_len)
		else $error("excitation window length wrong");
	property p_exc_half; $rose(excite_high_o) |-> exc_cnt == 8'h14; endproperty
	a_exc_half: assert property (p_exc_half)
		else $error("high current half starts at wrong cycle");
	property p_high_in; excite_high_o |-> excite_o; endproperty
	a_high_in: assert property (p_high_in)
		else $error("high current outside window");
	// Excitation only in diode mode, on the temperature channel.
	property p_exc_mode; excite_o |-> diode_mode_o; endproperty
	a_exc_mode: assert property (p_exc_mode)
		else $error("excitation without diode mode");
	property p_exc_chan; excite_o |-> adc_chan_o == CH_TEMP && busy_o; endproperty
	a_exc_chan: assert property (p_exc_chan)
		else $error("excitation outside temperature channel");
	property p_diode_mode; diode_mode_o |-> mode_i.op_mode == MODE_TEMP && !mode_i.powerdown; endproperty
	a_diode_mode: assert property (p_diode_mode)
		else $error("diode mode without temperature mode");

	// Main scenarios.
	c_excite: cover property ($fell(excite_o));
	c_shunt: cover property (adc_sample_o && adc_chan_o == CH_SHUNT);
	c_diode: cover property ($rose(diode_mode_o));
endmodule : pmrp_monitor_chk

bind pmrp_monitor pmrp_monitor_chk #(.CONV_CYC(CONV_CYC)) u_chk (.clk_i, .resetn_i, .req_i, .rdata_o,
	.mode_i, .adc_chan_o, .adc_sample_o, .diode_mode_o, .excite_o, .excite_high_o, .busy_o);

/* tb/testbench.sv */
`timescale 1ns/10ps

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end

// Self-checking bench for the monitor.
module testbench
	import pmrp_pkg::*;
();
	// Block ports and converter levels.
	logic        clk_i, resetn_i, trigger_i;
	pmrp_req_s   req_i;
	pmrp_mode_s  mode_i;
	logic [15:0] rdata_o, adc_data_i, shunt_v, bus_v, temp_v;
	logic [1:0]  adc_chan_o;
	logic        adc_sample_o, diode_mode_o, excite_o, excite_high_o, busy_o;
	int          failures = 0;
	int          n_checks = 0;
	int          n_samp;
	int          cyc      = 0;
	int          samp_at  = 0;
	int          samp_gap = 0;
	logic [15:0] sv [3] = '{16'h0064, 16'hffce, 16'h012c};

	pmrp_monitor #(.CONV_CYC(4)) uut (.clk_i, .resetn_i, .req_i, .rdata_o, .mode_i, .trigger_i,
		.adc_data_i, .adc_chan_o, .adc_sample_o, .diode_mode_o, .excite_o, .excite_high_o, .busy_o);
	pmrp_adc_model u_adc (.chan_i(adc_chan_o), .shunt_i(shunt_v), .bus_i(bus_v), .temp_i(temp_v),
		.data_o(adc_data_i));

	// Clock and sample counter.
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// Samples are counted off the falling edge, where the pulse has settled.
	always @(negedge clk_i) begin
		cyc++;
		if (adc_sample_o === 1'b1) begin
			n_samp++;
			samp_gap = cyc - samp_at;
			samp_at  = cyc;
		end
	end

	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(negedge clk_i);
		req_i = '{c, 1'b1, 1'b0, d};
		@(negedge clk_i);
		req_i.wr = 1'b0;
	endtask : wr

	task automatic rc(input logic [7:0] c, input logic [15:0] e);
		@(negedge clk_i);
		req_i = '{c, 1'b0, 1'b1, 16'h0000};
		@(negedge clk_i);
		req_i.rd = 1'b0;
		`CHK(rdata_o, e)
	endtask : rc

	task automatic md(input logic pd, input logic ct, input logic [2:0] op);
		@(negedge clk_i);
		mode_i = '{pd, ct, op};
	endtask : md

	// Waits for the sequencer to go idle, then lets results settle.
	task automatic idle_wait(input int lim);
		int k;
		for (k = 0; k < lim && busy_o !== 1'b0; k++) @(negedge clk_i);
		if (k == lim) failures++;
		repeat (4) @(negedge clk_i);
	endtask : idle_wait

	task automatic run_pass(input int lim);
		n_samp = 0;
		@(negedge clk_i);
		trigger_i = 1'b1;
		@(negedge clk_i);
		trigger_i = 1'b0;
		idle_wait(lim);
	endtask : run_pass

	task automatic t_regs();
		rc(CMD_GAIN, 16'h0000);
		rc(CMD_VCFG, 16'h0387);
		rc(CMD_PEAK_CFG, 16'h0000);
		rc(CMD_EXCITE, 16'h0000);
		`CHK(diode_mode_o, 1'b0)
		wr(CMD_GAIN, 16'hffff);
		rc(CMD_GAIN, 16'h7fff);
		wr(CMD_VCFG, 16'hffff);
		rc(CMD_VCFG, 16'h3fff);
		wr(CMD_PEAK_CFG, 16'h00ff);
		rc(CMD_PEAK_CFG, 16'h0001);
		wr(CMD_VCFG, 16'h0000);
		wr(CMD_ICFG, 16'h0000);
		wr(CMD_GAIN, 16'h1800);
		wr(CMD_PEAK_CFG, 16'h0000);
	endtask : t_regs

	// Bus value is a large negative number if read as signed current.
	task automatic t_peak();
		logic signed [15:0] c, mn, mx;
		md(1'b0, 1'b0, MODE_SHUNT_BUS);
		bus_v = 16'h8123;
		wr(CMD_PEAK_CFG, 16'h0001);
		for (int i = 0; i < 3; i++) begin
			shunt_v = sv[i];
			c = 16'(sv[i] * 16'h0003);
			mn = (i == 0 || c < mn) ? c : mn;
			mx = (i == 0 || c > mx) ? c : mx;
			run_pass(2000);
			rc(CMD_SHUNT_RES, sv[i]);
			rc(CMD_CUR_RES, c);
			rc(CMD_PEAK_MIN, mn);
			rc(CMD_PEAK_MAX, mx);
		end
		rc(CMD_BUS_RES, 16'h8123);
		wr(CMD_PEAK_CFG, 16'h0000);
		rc(CMD_PEAK_MIN, 16'h0000);
		rc(CMD_PEAK_MAX, 16'h0000);
	endtask : t_peak

	task automatic t_cont();
		shunt_v = 16'h0010;
		wr(CMD_PEAK_CFG, 16'h0001);
		md(1'b0, 1'b1, MODE_SHUNT);
		repeat (200) @(negedge clk_i);
		md(1'b0, 1'b0, MODE_SHUNT);
		idle_wait(2000);
		rc(CMD_PEAK_MIN, 16'h0030);
		rc(CMD_PEAK_MAX, 16'h0030);
	endtask : t_cont

	task automatic t_avg();
		wr(CMD_ICFG, 16'h0018);
		run_pass(2000);
		`CHK(n_samp, 8)
		wr(CMD_ICFG, 16'h0060);
		run_pass(40000);
		`CHK(n_samp, 4096)
		rc(CMD_SHUNT_RES, 16'h0010);
		wr(CMD_ICFG, 16'h0000);
	endtask : t_avg

	// Two samples per pass; their spacing is 4 cycles per 64us of conversion time.
	task automatic t_ctime();
		logic [2:0] ct_codes [3] = '{3'h3, 3'h5, 3'h6};
		int         ct_gaps  [3] = '{32, 64, 128};
		for (int i = 0; i < 3; i++) begin
			wr(CMD_ICFG, {13'h0001, ct_codes[i]});
			run_pass(2000);
			`CHK(n_samp, 2)
			`CHK(samp_gap, ct_gaps[i])
		end
		wr(CMD_ICFG, 16'h0000);
	endtask : t_ctime

	// The excitation bit alone must not arm; the powered-down sequence must.
	task automatic t_diode();
		temp_v = 16'hfe0c;
		wr(CMD_ICFG, 16'h0400);
		md(1'b0, 1'b0, MODE_TEMP);
		wr(CMD_EXCITE, 16'h0001);
		@(negedge clk_i);
		`CHK(diode_mode_o, 1'b0)
		wr(CMD_EXCITE, 16'h0000);
		md(1'b1, 1'b0, MODE_TEMP);
		wr(CMD_EXCITE, 16'h0001);
		md(1'b0, 1'b0, MODE_TEMP);
		@(negedge clk_i);
		`CHK(diode_mode_o, 1'b1)
		run_pass(2000);
		`CHK(n_samp, 2)
		rc(CMD_TEMP_RES, 16'hfe0c);
		rc(CMD_PEAK_MAX, 16'h0030);
		md(1'b1, 1'b0, MODE_TEMP);
		wr(CMD_EXCITE, 16'h0000);
		md(1'b0, 1'b0, MODE_SHUNT);
		@(negedge clk_i);
		`CHK(diode_mode_o, 1'b0)
	endtask : t_diode

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	// Reset, then the scenarios in turn.
	initial begin
		resetn_i = 1'b0;
		trigger_i = 1'b0;
		req_i = '0;
		mode_i = '0;
		{shunt_v, bus_v, temp_v} = '0;
		repeat (8) @(negedge clk_i);
		resetn_i = 1'b1;
		t_regs();
		t_peak();
		t_cont();
		t_avg();
		t_ctime();
		t_diode();
		wrap_up();
	end

	// Watchdog well beyond the expected run length.
	initial begin
		#1500000;
		failures++;
		wrap_up();
	end
endmodule : testbench

/* verilog/pmrp_monitor.sv */
// Behaviour
// - voltage config holds bus/aux time and averaging; its aux fields are unused, aux takes the shunt config aux fields
// - three-bit code selects 64us up to 2.048ms
// - four-bit code selects 2^n or 4096 averages
// - peak config bit 0 enables min/max tracking
// - each current result updates min and max
// - tracking uses only the current result
// - tracking same in triggered and continuous
// - disabling tracking clears min and max
// - excitation clear gives plain aux differential
// - excitation bit alone does not start diode
// - mode value six selects temperature only
// - diode mode in both modes, exit reversing
// - two diode currents held within 1us
// - diode difference stored signed, 10uV per count
// - diode timing follows aux shunt settings
// - shunt result signed, 2.5uV per count
// - bus result unsigned, 1mV or 250uV
// - current from shunt and 15-bit gain
`timescale 1ns/10ps

module pmrp_monitor
	import pmrp_pkg::*;
#(
	parameter int CONV_CYC = CONV_BASE_CYC
) (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// Register access.
	input  wire pmrp_req_s   req_i,
	output logic [15:0]      rdata_o,
	// Mode register fields and trigger.
	input  wire pmrp_mode_s  mode_i,
	input  wire logic        trigger_i,
	// Converter.
	input  wire logic [15:0] adc_data_i,
	output logic [1:0]       adc_chan_o,
	output logic             adc_sample_o,
	// Aux input front end.
	output logic             diode_mode_o,
	output logic             excite_o,
	output logic             excite_high_o,
	output logic             busy_o
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXCITE,
		ST_CONVERT
	} pmrp_state_e;

	// Reports whether a channel belongs to the selected mode.
	function automatic logic chan_used(input logic [1:0] ch, input logic [2:0] mode);
		logic used;
		used = 1'b0;
		case (ch)
			CH_SHUNT: used = (mode == MODE_SHUNT) || (mode == MODE_SHUNT_BUS) || (mode == MODE_ALL);
			CH_BUS:   used = (mode == MODE_BUS) || (mode == MODE_SHUNT_BUS) || (mode == MODE_ALL);
			CH_TEMP:  used = (mode == MODE_TEMP) || (mode == MODE_ALL);
			default:  used = 1'b0;
		endcase
		return used;
	endfunction : chan_used

	// First used channel at or above the given one, or none.
	function automatic logic [1:0] next_chan(input logic [2:0] from, input logic [2:0] mode);
		logic [1:0] nxt;
		nxt = CH_NONE;
		for (int c = 2; c >= 0; c--) begin
			if ((3'(c) >= from) && chan_used(2'(c), mode)) begin
				nxt = 2'(c);
			end
		end
		return nxt;
	endfunction : next_chan

	function automatic logic [31:0] conv_cycles(input logic [2:0] code);
		logic [2:0] sh;
		sh = code[2] ? (code[1] ? 3'h5 : 3'h4) : {1'b0, code[1:0]};
		return 32'(CONV_CYC) << sh;
	endfunction : conv_cycles

	function automatic logic [3:0] avg_shift(input logic [3:0] code);
		return (code[3:2] == 2'h3) ? 4'(AVG_MAX_SHIFT) : code;
	endfunction : avg_shift

	// Conversion-time code of a channel; the diode channel uses the aux shunt field.
	function automatic logic [2:0] ct_sel(input logic [1:0] ch, input logic [CFG_WIDTH-1:0] icfg,
		input logic [CFG_WIDTH-1:0] vcfg);
		return (ch == CH_SHUNT) ? icfg[PRI_CT_LSB +: 3] :
		       (ch == CH_BUS)   ? vcfg[PRI_CT_LSB +: 3] : icfg[AUX_CT_LSB +: 3];
	endfunction : ct_sel

	// Registers.
	logic [GAIN_WIDTH-1:0] gain_reg;
	logic [CFG_WIDTH-1:0]  icfg_reg;
	logic [CFG_WIDTH-1:0]  vcfg_reg;
	logic                  peak_en_reg;
	logic                  exc_en_reg;
	logic                  armed_reg;
	logic [15:0]           shunt_res_reg;
	logic [15:0]           bus_res_reg;
	logic [15:0]           cur_res_reg;
	logic [15:0]           temp_res_reg;
	logic [15:0]           peak_min_reg;
	logic [15:0]           peak_max_reg;
	logic                  peak_fresh_reg;
	logic                  cur_upd_reg;
	logic [15:0]           rdata_reg;
	pmrp_state_e           state_reg;
	pmrp_state_e           state_next;
	logic [1:0]            chan_reg;
	logic [1:0]            chan_next;
	logic [31:0]           timer_reg;
	logic [31:0]           timer_next;
	logic [11:0]           count_reg;
	logic [ACC_WIDTH-1:0]  acc_reg;
	logic                  sample_reg;

	// Access decode.
	wire logic wr_gain  = req_i.wr && (req_i.cmd == CMD_GAIN);
	wire logic wr_icfg  = req_i.wr && (req_i.cmd == CMD_ICFG);
	wire logic wr_vcfg  = req_i.wr && (req_i.cmd == CMD_VCFG);
	wire logic wr_peak  = req_i.wr && (req_i.cmd == CMD_PEAK_CFG);
	wire logic wr_exc   = req_i.wr && (req_i.cmd == CMD_EXCITE);

	// diode mode needs the full entry sequence
	wire logic ext_active = armed_reg && !mode_i.powerdown && (mode_i.op_mode == MODE_TEMP);

	// Per channel settings; diode conversions use the aux shunt fields.
	// diode follows aux shunt setting
	wire logic [2:0] ct_code  = ct_sel(chan_reg, icfg_reg, vcfg_reg);
	wire logic [3:0] avg_code = (chan_reg == CH_SHUNT) ? icfg_reg[PRI_AVG_LSB +: 4] :
	                            (chan_reg == CH_BUS)   ? vcfg_reg[PRI_AVG_LSB +: 4] : icfg_reg[AUX_AVG_LSB +: 4];
	wire logic [3:0]  avg_sh     = avg_shift(avg_code);
	wire logic [11:0] last_count = 12'((13'h0001 << avg_sh) - 13'h0001);
	wire logic        start      = !mode_i.powerdown && (mode_i.continuous || trigger_i);
	wire logic [1:0]  first_chan = next_chan(3'h0, mode_i.op_mode);
	wire logic [1:0]  after_chan = next_chan(3'({1'b0, chan_reg} + 3'h1), mode_i.op_mode);
	// Conversion time of the channel that follows, so each channel keeps its own timing.
	wire logic [2:0]  ct_after   = ct_sel((after_chan != CH_NONE) ? after_chan : first_chan, icfg_reg, vcfg_reg);
	wire logic        diode_step = ext_active && (chan_reg == CH_TEMP);
	wire logic        take       = (state_reg == ST_CONVERT) && (timer_reg == 32'h0);
	wire logic        chan_done  = take && (count_reg == last_count);

	// bus samples are unsigned, others signed
	wire logic [ACC_WIDTH-1:0] sample_ext = (chan_reg == CH_BUS) ? ACC_WIDTH'({1'b0, adc_data_i}) :
	                                        ACC_WIDTH'(signed'(adc_data_i));
	wire logic [ACC_WIDTH-1:0] acc_sum = acc_reg + sample_ext;
	wire logic [ACC_WIDTH-1:0] avg_out = (chan_reg == CH_BUS) ? (acc_sum >> avg_sh) :
	                                     ACC_WIDTH'(signed'(acc_sum) >>> avg_sh);

	// current from shunt result and gain
	wire logic signed [31:0] cur_prod = signed'(shunt_res_reg) * signed'({1'b0, gain_reg});
	wire logic signed [31:0] cur_scl  = cur_prod >>> MATH_SHIFT;
	wire logic               cur_hi   = (cur_scl > 32'sh00007fff);
	wire logic               cur_lo   = (cur_scl < -32'sh00008000);
	wire logic [15:0]        cur_val  = cur_hi ? 16'h7fff : (cur_lo ? 16'h8000 : cur_scl[15:0]);

	// Read data select.
	wire logic [15:0] rd_sel =
		(req_i.cmd == CMD_GAIN)      ? {1'b0, gain_reg} :
		(req_i.cmd == CMD_BUS_RES)   ? bus_res_reg :
		(req_i.cmd == CMD_CUR_RES)   ? cur_res_reg :
		(req_i.cmd == CMD_TEMP_RES)  ? temp_res_reg :
		(req_i.cmd == CMD_ICFG)      ? {2'h0, icfg_reg} :
		(req_i.cmd == CMD_VCFG)      ? {2'h0, vcfg_reg} :
		(req_i.cmd == CMD_SHUNT_RES) ? shunt_res_reg :
		(req_i.cmd == CMD_PEAK_CFG)  ? {15'h0000, peak_en_reg} :
		(req_i.cmd == CMD_PEAK_MIN)  ? peak_min_reg :
		(req_i.cmd == CMD_PEAK_MAX)  ? peak_max_reg :
		(req_i.cmd == CMD_EXCITE)    ? {15'h0000, exc_en_reg} : 16'h0000;

	// Sequencer next state: excite the diode, convert, step channels.
	always_comb begin
		state_next = state_reg;
		chan_next  = chan_reg;
		timer_next = (timer_reg != 32'h0) ? timer_reg - 32'h1 : 32'h0;
		case (state_reg)
			ST_IDLE: begin
				if (start && (first_chan != CH_NONE)) begin
					chan_next  = first_chan;
					state_next = (ext_active && (first_chan == CH_TEMP)) ? ST_EXCITE : ST_CONVERT;
					timer_next = (state_next == ST_EXCITE) ? 32'(EXCITE_CYC - 1) : 32'h0;
				end
			end
			ST_EXCITE: begin
				if (mode_i.powerdown) begin
					state_next = ST_IDLE;
				end else if (timer_reg == 32'h0) begin
					state_next = ST_CONVERT;
					timer_next = conv_cycles(ct_code) - 32'h1;
				end
			end
			ST_CONVERT: begin
				if (mode_i.powerdown) begin
					state_next = ST_IDLE;
				end else if (chan_done) begin
					chan_next = (after_chan != CH_NONE) ? after_chan : first_chan;
					if ((after_chan == CH_NONE) && !mode_i.continuous) begin
						state_next = ST_IDLE;
					end else if (ext_active && (chan_next == CH_TEMP)) begin
						state_next = ST_EXCITE;
						timer_next = 32'(EXCITE_CYC - 1);
					end else begin
						timer_next = conv_cycles(ct_after) - 32'h1;
					end
				end else if (take && diode_step) begin
					state_next = ST_EXCITE;
					timer_next = 32'(EXCITE_CYC - 1);
				end else if (take) begin
					timer_next = conv_cycles(ct_code) - 32'h1;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// Sequencer state, sample count and accumulator.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg  <= ST_IDLE;
			chan_reg   <= CH_SHUNT;
			timer_reg  <= 32'h0;
			count_reg  <= 12'h000;
			acc_reg    <= '0;
			sample_reg <= 1'b0;
		end else begin
			state_reg  <= state_next;
			chan_reg   <= chan_next;
			timer_reg  <= timer_next;
			sample_reg <= take;
			if ((state_reg == ST_IDLE) || chan_done) begin
				count_reg <= 12'h000;
				acc_reg   <= '0;
			end else if (take) begin
				count_reg <= count_reg + 12'h001;
				acc_reg   <= acc_sum;
			end
		end
	end

	// Configuration registers written by the host.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			gain_reg    <= GAIN_RESET;
			icfg_reg    <= CFG_RESET;
			vcfg_reg    <= CFG_RESET;
			peak_en_reg <= 1'b0;
			exc_en_reg  <= 1'b0;
		end else begin
			if (wr_gain) gain_reg <= req_i.wdata[GAIN_WIDTH-1:0];
			if (wr_icfg) icfg_reg <= req_i.wdata[CFG_WIDTH-1:0];
			if (wr_vcfg) vcfg_reg <= req_i.wdata[CFG_WIDTH-1:0];
			if (wr_peak) peak_en_reg <= req_i.wdata[PEAK_EN_BIT];
			if (wr_exc) exc_en_reg <= req_i.wdata[EXC_EN_BIT];
		end
	end

	// Diode arming: excitation set while powered down, dropped with the bit.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			armed_reg <= 1'b0;
		end else begin
			if (!exc_en_reg) armed_reg <= 1'b0;
			else if (mode_i.powerdown) armed_reg <= 1'b1;
		end
	end

	// Result registers updated at the end of each averaging run.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			shunt_res_reg <= 16'h0000;
			bus_res_reg   <= 16'h0000;
			temp_res_reg  <= 16'h0000;
			cur_res_reg   <= 16'h0000;
			cur_upd_reg   <= 1'b0;
		end else begin
			cur_upd_reg <= 1'b0;
			if (chan_done) begin
				case (chan_reg)
					CH_SHUNT: begin
						shunt_res_reg <= avg_out[15:0];
						cur_upd_reg   <= 1'b1;
					end
					CH_BUS:   bus_res_reg <= avg_out[15:0];
					CH_TEMP:  temp_res_reg <= avg_out[15:0];
					default:  cur_upd_reg <= 1'b0;
				endcase
			end
			if (cur_upd_reg) cur_res_reg <= cur_val;
		end
	end

	// Min and max current tracking, held at zero while disabled.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			peak_min_reg   <= 16'h0000;
			peak_max_reg   <= 16'h0000;
			peak_fresh_reg <= 1'b1;
		end else if (!peak_en_reg) begin
			peak_min_reg   <= 16'h0000;
			peak_max_reg   <= 16'h0000;
			peak_fresh_reg <= 1'b1;
		end else if (cur_upd_reg) begin
			// only the current result feeds this
			peak_fresh_reg <= 1'b0;
			if (peak_fresh_reg || (signed'(cur_val) < signed'(peak_min_reg))) peak_min_reg <= cur_val;
			if (peak_fresh_reg || (signed'(cur_val) > signed'(peak_max_reg))) peak_max_reg <= cur_val;
		end
	end

	// Read data captured on a read strobe.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) rdata_reg <= 16'h0000;
		else if (req_i.rd) rdata_reg <= rd_sel;
	end

	// Outputs; the diode current steps low then high within 1us.
	assign rdata_o       = rdata_reg;
	assign adc_chan_o    = chan_reg;
	assign adc_sample_o  = sample_reg;
	assign diode_mode_o  = ext_active;
	// two currents, each half the window
	assign excite_o      = (state_reg == ST_EXCITE);
	assign excite_high_o = (state_reg == ST_EXCITE) && (timer_reg < 32'(EXCITE_HALF_CYC));
	assign busy_o        = (state_reg != ST_IDLE);

endmodule : pmrp_monitor
